// >>> rtl/srw_pkg.sv
// Package for the reset supervisor with watchdog: constants, register map and carrier types
package srw_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam longint SRW_CLK_PERIOD_NS = 64'd20;      // 50 MHz system clock
   localparam int     SRW_CNT_W         = 36;          // Wide enough for the long watchdog window

   localparam longint SRW_HOLD_SHORT_MS = 64'd10;      // Short hold time, select low (min)
   localparam longint SRW_HOLD_LONG_MS  = 64'd150;     // Long hold time, select high (min)
   localparam longint SRW_HOLD_FIXED_MS = 64'd150;     // Factory fixed hold option (min)
   localparam real    SRW_WDOG_SHORT_S  = 1.5;         // Short watchdog window (min)
   localparam real    SRW_WDOG_LONG_S   = 95.0;        // Long watchdog window (min)
   localparam longint SRW_UV_GLITCH_NS  = 64'd40000;   // Supply dips this short are ignored

   // Least times, exact multiples of the clock period here
   localparam logic [SRW_CNT_W-1:0] SRW_HOLD_SHORT_CYC =
      SRW_CNT_W'((SRW_HOLD_SHORT_MS * 64'd1000000 + SRW_CLK_PERIOD_NS - 64'd1) / SRW_CLK_PERIOD_NS);
   localparam logic [SRW_CNT_W-1:0] SRW_HOLD_LONG_CYC  =
      SRW_CNT_W'((SRW_HOLD_LONG_MS * 64'd1000000 + SRW_CLK_PERIOD_NS - 64'd1) / SRW_CLK_PERIOD_NS);
   localparam logic [SRW_CNT_W-1:0] SRW_HOLD_FIXED_CYC =
      SRW_CNT_W'((SRW_HOLD_FIXED_MS * 64'd1000000 + SRW_CLK_PERIOD_NS - 64'd1) / SRW_CLK_PERIOD_NS);
   localparam logic [SRW_CNT_W-1:0] SRW_WDOG_SHORT_CYC =
      SRW_CNT_W'(longint'(SRW_WDOG_SHORT_S * 1.0e9) / SRW_CLK_PERIOD_NS);
   localparam logic [SRW_CNT_W-1:0] SRW_WDOG_LONG_CYC  =
      SRW_CNT_W'(longint'(SRW_WDOG_LONG_S * 1.0e9) / SRW_CLK_PERIOD_NS);
   // Longest ignored dip rounds down
   localparam logic [11:0] SRW_UV_GLITCH_CYC = 12'(SRW_UV_GLITCH_NS / SRW_CLK_PERIOD_NS);

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int          SRW_ADDR_W     = 4;
   localparam logic [3:0]  SRW_OFF_CTRL   = 4'h0;      // Control, read/write
   localparam logic [3:0]  SRW_OFF_STATUS = 4'h4;      // Live status, read only
   localparam logic [3:0]  SRW_OFF_CAUSE  = 4'h8;      // Sticky causes, write one to clear
   localparam logic [1:0]  SRW_RESP_OKAY  = 2'b00;
   localparam logic [1:0]  SRW_RESP_SLVERR = 2'b10;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic mr_en;          // Manual reset input honoured
      logic hold_pin_sel;   // Hold time from select pin, else fixed option
      logic wdog_long;      // Long watchdog window option
      logic wdog_en;        // Watchdog fitted and running
   } srw_ctrl_t;

   localparam srw_ctrl_t SRW_CTRL_RESET = '{mr_en: 1'b1, hold_pin_sel: 1'b1, wdog_long: 1'b0, wdog_en: 1'b1};

   typedef struct packed {
      logic wd;             // Watchdog expired
      logic mr;             // Manual reset seen
      logic uv;             // Undervoltage seen
   } srw_cause_t;

   typedef enum logic [1:0] {
      SRW_ST_RUN,           // Reset released, watchdog counting
      SRW_ST_ACTIVE,        // A level cause is present
      SRW_ST_HOLD           // Causes gone, hold time running
   } srw_state_t;

endpackage

// >>> rtl/srw_top.sv
// Reset supervisor: undervoltage, manual reset and watchdog combined into one reset, driven on an active-low and an active-high output
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module srw_top
   import srw_pkg::*;
#(
   parameter logic [SRW_CNT_W-1:0] HOLD_SHORT_CYC = SRW_HOLD_SHORT_CYC, // Short hold, cycles
   parameter logic [SRW_CNT_W-1:0] HOLD_LONG_CYC  = SRW_HOLD_LONG_CYC,  // Long hold, cycles
   parameter logic [SRW_CNT_W-1:0] HOLD_FIXED_CYC = SRW_HOLD_FIXED_CYC, // Fixed hold, cycles
   parameter logic [SRW_CNT_W-1:0] WDOG_SHORT_CYC = SRW_WDOG_SHORT_CYC, // Short window, cycles
   parameter logic [SRW_CNT_W-1:0] WDOG_LONG_CYC  = SRW_WDOG_LONG_CYC   // Long window, cycles
)(
   input  wire logic                  aclk,              // System clock
   input  wire logic                  aresetn,           // Synchronous reset, active low
   input  wire logic [SRW_ADDR_W-1:0] s_axi_awaddr,      // Write address
   input  wire logic [2:0]            s_axi_awprot,      // Write protection, unused
   input  wire logic                  s_axi_awvalid,     // Write address valid
   output var  logic                  s_axi_awready,     // Write address ready
   input  wire logic [31:0]           s_axi_wdata,       // Write data
   input  wire logic [3:0]            s_axi_wstrb,       // Write byte strobes
   input  wire logic                  s_axi_wvalid,      // Write data valid
   output var  logic                  s_axi_wready,      // Write data ready
   output var  logic [1:0]            s_axi_bresp,       // Write response
   output var  logic                  s_axi_bvalid,      // Write response valid
   input  wire logic                  s_axi_bready,      // Write response ready
   input  wire logic [SRW_ADDR_W-1:0] s_axi_araddr,      // Read address
   input  wire logic [2:0]            s_axi_arprot,      // Read protection, unused
   input  wire logic                  s_axi_arvalid,     // Read address valid
   output var  logic                  s_axi_arready,     // Read address ready
   output var  logic [31:0]           s_axi_rdata,       // Read data
   output var  logic [1:0]            s_axi_rresp,       // Read response
   output var  logic                  s_axi_rvalid,      // Read data valid
   input  wire logic                  s_axi_rready,      // Read data ready
   input  wire logic                  undervoltage_in,   // Supply below trip threshold, high
   input  wire logic                  manual_reset_n,    // Manual reset pin, active low
   input  wire logic                  watchdog_kick_in,  // Watchdog kick pin
   input  wire logic                  hold_time_select,  // Hold time select pin
   output var  logic                  reset_out_n,       // Reset output, active low
   output var  logic                  reset_out          // Reset output, active high
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Last cycle of an interval of len cycles
   function automatic logic cnt_done(input logic [SRW_CNT_W-1:0] cnt,
                                     input logic [SRW_CNT_W-1:0] len);
      cnt_done = (cnt == (len - SRW_CNT_W'(1)));
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] pin_meta_reg;    // First stage, read only by second
   logic [3:0] pin_sync_reg;    // Second stage: uv, mr_n, kick, select
   logic       kick_last_reg;   // Previous synchronised kick level

   // Two flops per pin; the pipeline catches any level held >= one period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Kick stages reset low like kick_last_reg, so no false edge follows reset
         pin_meta_reg  <= 4'b0100;
         pin_sync_reg  <= 4'b0100;
         kick_last_reg <= 1'b0;
      end else begin
         pin_meta_reg  <= {undervoltage_in, manual_reset_n, watchdog_kick_in, hold_time_select};
         pin_sync_reg  <= pin_meta_reg;
         kick_last_reg <= pin_sync_reg[1];
      end
   end

   wire uv_s    = pin_sync_reg[3];        // Undervoltage level
   wire mr_n_s  = pin_sync_reg[2];        // Manual reset level
   wire kick_s  = pin_sync_reg[1];        // Kick level
   wire sel_s   = pin_sync_reg[0];        // Hold select level
   // 150ns spans seven clocks, so every such pulse leaves an edge here
   wire kick_edge = kick_s ^ kick_last_reg;

   // ----------------------------------------------------------------
   // Registers and live state
   // ----------------------------------------------------------------
   srw_ctrl_t             ctrl_reg;       // Software control
   srw_cause_t            cause_reg;      // Sticky causes
   srw_state_t            state_reg;      // Supervisor state
   srw_state_t            state_next;
   logic [11:0]           uv_cnt_reg;     // Dip length counter
   logic                  uv_filt_reg;    // Qualified undervoltage
   logic [SRW_CNT_W-1:0]  hold_cnt_reg;   // Hold timer
   logic [SRW_CNT_W-1:0]  hold_len_reg;   // Hold length latched at start
   logic [SRW_CNT_W-1:0]  wd_cnt_reg;     // Watchdog timer

   // Pin pulled high when undriven; the enable bit lets software ignore it too
   wire mr_act = ctrl_reg.mr_en & ~mr_n_s;
   wire cause_lvl = uv_filt_reg | mr_act;
   wire rst_asserted = (state_reg != SRW_ST_RUN);
   wire [SRW_CNT_W-1:0] wd_len = ctrl_reg.wdog_long ? WDOG_LONG_CYC : WDOG_SHORT_CYC;
   wire wd_expire = ctrl_reg.wdog_en & ~rst_asserted & ~mr_act & ~kick_edge
                    & cnt_done(wd_cnt_reg, wd_len);
   // Pin select when fitted, otherwise the factory option
   wire [SRW_CNT_W-1:0] hold_len_sel = ctrl_reg.hold_pin_sel ?
                                       (sel_s ? HOLD_LONG_CYC : HOLD_SHORT_CYC) :
                                       HOLD_FIXED_CYC;

   // ----------------------------------------------------------------
   // Supply glitch filter
   // ----------------------------------------------------------------
   // A dip must outlast the ignored span before it counts; trades a
   // 40us reaction delay for immunity to short supply transients
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         uv_cnt_reg  <= 12'h000;
         uv_filt_reg <= 1'b0;
      end else if (!uv_s) begin
         uv_cnt_reg  <= 12'h000;
         uv_filt_reg <= 1'b0;
      end else if (uv_cnt_reg == SRW_UV_GLITCH_CYC) begin
         uv_filt_reg <= 1'b1;
      end else begin
         uv_cnt_reg  <= uv_cnt_reg + 12'h001;
      end
   end

   // ----------------------------------------------------------------
   // Supervisor state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SRW_ST_RUN: begin
            if (cause_lvl) begin
               state_next = SRW_ST_ACTIVE;
            end else if (wd_expire) begin
               state_next = SRW_ST_HOLD;
            end
         end
         SRW_ST_ACTIVE: begin
            if (!cause_lvl) begin
               state_next = SRW_ST_HOLD;
            end
         end
         SRW_ST_HOLD: begin
            if (cause_lvl) begin
               state_next = SRW_ST_ACTIVE;
            end else if (cnt_done(hold_cnt_reg, hold_len_reg)) begin
               state_next = SRW_ST_RUN;
            end
         end
         default: begin
            state_next = SRW_ST_ACTIVE;
         end
      endcase
   end

   // Power-up starts asserted so the first hold interval is timed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= SRW_ST_ACTIVE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Hold timer; length sampled only when an interval starts
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_cnt_reg <= '0;
         hold_len_reg <= HOLD_FIXED_CYC;
      end else if (state_next == SRW_ST_HOLD && state_reg != SRW_ST_HOLD) begin
         hold_cnt_reg <= '0;
         hold_len_reg <= hold_len_sel;
      end else if (state_reg == SRW_ST_HOLD) begin
         hold_cnt_reg <= hold_cnt_reg + SRW_CNT_W'(1);
      end
   end

   // Watchdog timer: cleared and frozen while reset is out
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wd_cnt_reg <= '0;
      end else if (rst_asserted || mr_act || kick_edge || wd_expire || !ctrl_reg.wdog_en) begin
         wd_cnt_reg <= '0;
      end else begin
         wd_cnt_reg <= wd_cnt_reg + SRW_CNT_W'(1);
      end
   end

   // Both polarities follow the registered state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reset_out_n <= 1'b0;
         reset_out   <= 1'b1;
      end else begin
         reset_out_n <= (state_next == SRW_ST_RUN);
         reset_out   <= (state_next != SRW_ST_RUN);
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   logic                  aw_have_reg;    // Write address held
   logic                  w_have_reg;     // Write data held
   logic [SRW_ADDR_W-1:0] aw_addr_reg;
   logic [31:0]           w_data_reg;
   logic [3:0]            w_strb_reg;

   assign s_axi_awready = ~aw_have_reg;
   assign s_axi_wready  = ~w_have_reg;
   assign s_axi_arready = ~s_axi_rvalid;

   wire do_write  = aw_have_reg & w_have_reg & ~s_axi_bvalid;
   wire wr_ctrl   = do_write & (aw_addr_reg == SRW_OFF_CTRL) & w_strb_reg[0];
   wire wr_cause  = do_write & (aw_addr_reg == SRW_OFF_CAUSE) & w_strb_reg[0];
   wire wr_ok     = (aw_addr_reg == SRW_OFF_CTRL) | (aw_addr_reg == SRW_OFF_CAUSE)
                    | (aw_addr_reg == SRW_OFF_STATUS);
   wire do_read   = s_axi_arvalid & s_axi_arready;
   wire rd_ctrl   = (s_axi_araddr == SRW_OFF_CTRL);
   wire rd_status = (s_axi_araddr == SRW_OFF_STATUS);
   wire rd_cause  = (s_axi_araddr == SRW_OFF_CAUSE);
   wire [31:0] status_word = {25'h000_0000, state_reg == SRW_ST_HOLD, rst_asserted, sel_s,
                              kick_s, mr_act, uv_filt_reg, ctrl_reg.wdog_en};
   wire [31:0] rd_word = rd_ctrl   ? {28'h000_0000, ctrl_reg} :
                         rd_status ? status_word :
                         rd_cause  ? {29'h000_0000, cause_reg} : 32'h0000_0000;
   wire srw_cause_t cause_set = '{wd: wd_expire, mr: mr_act, uv: uv_filt_reg};

   // Address and data taken in either order, held until both are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_have_reg) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (do_write) begin
            aw_have_reg <= 1'b0;
         end
         if (s_axi_wvalid && !w_have_reg) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (do_write) begin
            w_have_reg <= 1'b0;
         end
      end
   end

   // Write response; unmapped addresses answer with a slave error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= SRW_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? SRW_RESP_OKAY : SRW_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read data captured at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= SRW_RESP_OKAY;
      end else if (do_read) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= (rd_ctrl | rd_status | rd_cause) ? SRW_RESP_OKAY : SRW_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Control and sticky causes; a new event wins over its clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg  <= SRW_CTRL_RESET;
         cause_reg <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= srw_ctrl_t'(w_data_reg[3:0]);
         end
         cause_reg <= (cause_reg & ~(wr_cause ? srw_cause_t'(w_data_reg[2:0]) : '0)) | cause_set;
      end
   end

endmodule

`default_nettype wire

// >>> testbench/srw_chk.sv
// Checker: timing relations at the pins of the reset supervisor
`timescale 1ns/1ps
`default_nettype none
module srw_chk
   import srw_pkg::*;
#(
   parameter logic [SRW_CNT_W-1:0] HOLD_SHORT_CYC = SRW_HOLD_SHORT_CYC, // Shortest hold used
   parameter logic [SRW_CNT_W-1:0] WDOG_SHORT_CYC = SRW_WDOG_SHORT_CYC  // Watchdog window used
)(
   input wire logic aclk,             // System clock
   input wire logic aresetn,          // Synchronous reset, active low
   input wire logic undervoltage_in,  // Supply low, high
   input wire logic manual_reset_n,   // Manual reset pin
   input wire logic watchdog_kick_in, // Kick pin
   input wire logic reset_out_n,      // Reset output, active low
   input wire logic reset_out         // Reset output, active high
);
   // ----------------------------------------------------------------
   // Helper counters
   // ----------------------------------------------------------------
   logic [SRW_CNT_W-1:0] low_cnt;  // Cycles reset seen low
   logic [15:0]          uv_cnt;   // Cycles supply seen low
   logic [SRW_CNT_W-1:0] quiet;    // Released cycles without a kick edge
   logic                 kick_d;   // Kick level one cycle back

   // Only the supply counter saturates, at its full 16-bit width; the reset and quiet counters do not
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_cnt <= '0;
         uv_cnt  <= '0;
         quiet   <= '0;
         kick_d  <= watchdog_kick_in;
      end else begin
         low_cnt <= reset_out_n ? '0 : low_cnt + 1'b1;
         uv_cnt  <= !undervoltage_in ? '0 : (uv_cnt == 16'hFFFF ? uv_cnt : uv_cnt + 1'b1);
         quiet   <= (!reset_out_n || kick_d != watchdog_kick_in) ? '0 : quiet + 1'b1;
         kick_d  <= watchdog_kick_in;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_polarity;
      @(posedge aclk) disable iff (!aresetn) reset_out == !reset_out_n;
   endproperty
   a_polarity: assert property (p_polarity) else $error("reset outputs not complementary");
   property p_mr_assert;
      @(posedge aclk) disable iff (!aresetn) $fell(manual_reset_n) |-> ##[1:6] !reset_out_n;
   endproperty
   a_mr_assert: assert property (p_mr_assert) else $error("manual reset not asserted");
   property p_mr_held;
      @(posedge aclk) disable iff (!aresetn) (!manual_reset_n) [*6] |-> !reset_out_n;
   endproperty
   a_mr_held: assert property (p_mr_held) else $error("reset released while manual low");
   property p_min_hold;
      @(posedge aclk) disable iff (!aresetn) $rose(reset_out_n) |-> low_cnt >= HOLD_SHORT_CYC;
   endproperty
   a_min_hold: assert property (p_min_hold) else $error("reset pulse shorter than hold");
   property p_uv_long;
      @(posedge aclk) disable iff (!aresetn) uv_cnt > 16'h07DC |-> !reset_out_n;
   endproperty
   a_uv_long: assert property (p_uv_long) else $error("long undervoltage gave no reset");
   property p_glitch;
      @(posedge aclk) disable iff (!aresetn)
         $fell(undervoltage_in) && uv_cnt < 16'h07C6 && reset_out_n |-> reset_out_n [*6];
   endproperty
   a_glitch: assert property (p_glitch) else $error("short supply dip gave a reset");
   property p_wd_bound;
      @(posedge aclk) disable iff (!aresetn) quiet <= WDOG_SHORT_CYC + 8;
   endproperty
   a_wd_bound: assert property (p_wd_bound) else $error("watchdog did not expire in time");
   property p_restart;
      @(posedge aclk) disable iff (!aresetn) (!manual_reset_n) [*6] ##1 manual_reset_n |-> !reset_out_n [*8];
   endproperty
   a_restart: assert property (p_restart) else $error("hold not timed from cause end");
endmodule
bind srw_top srw_chk #(.HOLD_SHORT_CYC(HOLD_SHORT_CYC), .WDOG_SHORT_CYC(WDOG_SHORT_CYC)) i_srw_chk (
   .aclk(aclk), .aresetn(aresetn), .undervoltage_in(undervoltage_in), .manual_reset_n(manual_reset_n),
   .watchdog_kick_in(watchdog_kick_in), .reset_out_n(reset_out_n), .reset_out(reset_out));
`default_nettype wire

// >>> testbench/srw_cpu_model.sv
// Partner model: processor that kicks the watchdog and is held by the reset
`timescale 1ns/1ps
`default_nettype none
module srw_cpu_model #(
   parameter int KICK_GAP = 30       // Cycles between kick edges
)(
   input  wire logic aclk,           // System clock
   input  wire logic reset_in_n,     // Reset from supervisor
   input  wire logic run,            // Program healthy, else stuck in a loop
   output var  logic kick            // Watchdog kick pin
);
   int cnt;                          // Program position

   // Held in reset: program stopped, pin pulled low
   always_ff @(posedge aclk) begin
      if (!reset_in_n) begin
         cnt  <= 0;
         kick <= 1'b0;
      end else if (run) begin
         cnt <= (cnt == KICK_GAP - 1) ? 0 : cnt + 1;
         // Kick toggles once per program pass, every KICK_GAP cycles
         if (cnt == KICK_GAP - 1) begin
            kick <= ~kick;
         end
      end
   end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Testbench: register access and reset cause scenarios for the supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import srw_pkg::*;
   localparam int HS = 20;           // Short hold, cycles
   localparam int HL = 50;           // Long hold, cycles
   localparam int WD = 100;          // Short watchdog window, cycles
   localparam int HF = 30;           // Fixed hold option, cycles
   logic        aclk, aresetn, aw_valid, w_valid, b_ready, ar_valid, r_ready;
   logic [3:0]  aw_addr, ar_addr, w_strb;
   logic [31:0] w_data, s_rdata, rd;
   logic [1:0]  s_bresp, s_rresp, rr;
   logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic        uv_in, mr_n, sel, run, kick, rst_n, rst;
   int          err_count, samples_checked, n, i;

   srw_top #(.HOLD_SHORT_CYC(SRW_CNT_W'(HS)), .HOLD_LONG_CYC(SRW_CNT_W'(HL)), .HOLD_FIXED_CYC(SRW_CNT_W'(HF)),
      .WDOG_SHORT_CYC(SRW_CNT_W'(WD)), .WDOG_LONG_CYC(36'h12C)) i_srw_top (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_addr), .s_axi_awprot(3'h0), .s_axi_awvalid(aw_valid),
      .s_axi_awready(s_awready), .s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid),
      .s_axi_wready(s_wready), .s_axi_bresp(s_bresp), .s_axi_bvalid(s_bvalid), .s_axi_bready(b_ready),
      .s_axi_araddr(ar_addr), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_valid), .s_axi_arready(s_arready),
      .s_axi_rdata(s_rdata), .s_axi_rresp(s_rresp), .s_axi_rvalid(s_rvalid), .s_axi_rready(r_ready),
      .undervoltage_in(uv_in), .manual_reset_n(mr_n), .watchdog_kick_in(kick), .hold_time_select(sel),
      .reset_out_n(rst_n), .reset_out(rst));
   srw_cpu_model #(.KICK_GAP(30)) i_srw_cpu_model (.aclk(aclk), .reset_in_n(rst_n), .run(run), .kick(kick));

   always #10 aclk = ~aclk;          // 50 MHz

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic ok, input string what);
      samples_checked++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("Error at %0t ns: %s", $time, what);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask
   // Counts edges until reset output reaches v; a hang ends the run
   task automatic wait_lvl(input logic v, input int lim, output int k);
      for (k = 1; k <= lim; k++) begin
         @(posedge aclk);
         if (rst_n === v) return;
      end
      check(1'b0, "reset output wait ran out");
      give_verdict;
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      aw_addr <= a; w_data <= d; aw_valid <= 1'b1; w_valid <= 1'b1; b_ready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (s_awready) aw_valid <= 1'b0;
         if (s_wready) w_valid <= 1'b0;
         if (s_bvalid) break;
      end
      if (k == 50) begin check(1'b0, "write response missing"); give_verdict; end
      // Ready stays high: a next call would raise it again in the same step
      r = s_bresp;
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      ar_addr <= a; ar_valid <= 1'b1; r_ready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (s_arready) ar_valid <= 1'b0;
         if (s_rvalid) break;
      end
      if (k == 50) begin check(1'b0, "read data missing"); give_verdict; end
      d = s_rdata; r = s_rresp;
   endtask
   // Manual reset pulse; select may move once the hold has begun
   task automatic mr_hold(input logic s0, input logic s1, input int hold);
      int k;
      sel <= s0; mr_n <= 1'b0;
      cyc(8);
      check(rst_n === 1'b0 && rst === 1'b1, "manual reset not asserted");
      mr_n <= 1'b1;
      cyc(5);
      sel <= s1;
      wait_lvl(1'b1, 500, k);
      check(k + 5 >= hold + 1 && k + 5 <= hold + 8, "hold length after manual reset");
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      aclk = 1'b0; aresetn = 1'b0; aw_valid = 1'b0; w_valid = 1'b0; b_ready = 1'b0; ar_valid = 1'b0;
      r_ready = 1'b0; aw_addr = 4'h0; ar_addr = 4'h0; w_data = 32'h0000_0000; w_strb = 4'hF;
      uv_in = 1'b0; mr_n = 1'b1; sel = 1'b0; run = 1'b1; err_count = 0; samples_checked = 0;
      cyc(3);
      aresetn <= 1'b1;
      // Power-on hold, then register map
      wait_lvl(1'b1, 500, n);
      check(n >= HS, "power-on hold too short");
      axi_rd(SRW_OFF_CTRL, rd, rr);
      check(rd === 32'h0000_000D && rr === SRW_RESP_OKAY, "control reset value");
      axi_rd(4'hC, rd, rr);
      check(rd === 32'h0000_0000 && rr === SRW_RESP_SLVERR, "unmapped read");
      axi_wr(4'hC, 32'h0000_0001, rr);
      check(rr === SRW_RESP_SLVERR, "unmapped write");
      // Byte 0 not enabled: control, manual reset enable included, must stay
      w_strb <= 4'h0;
      axi_wr(SRW_OFF_CTRL, 32'h0000_0000, rr);
      w_strb <= 4'hF;
      axi_rd(SRW_OFF_CTRL, rd, rr);
      check(rd === 32'h0000_000D, "write without byte 0 applied");
      $display("Test power-on and registers done");
      // Select table: short, long, change during hold
      mr_hold(1'b0, 1'b0, HS);
      mr_hold(1'b1, 1'b1, HL);
      mr_hold(1'b0, 1'b1, HS);
      axi_rd(SRW_OFF_CAUSE, rd, rr);
      check(rd[1] === 1'b1, "manual cause not recorded");
      axi_wr(SRW_OFF_CAUSE, 32'h0000_0002, rr);
      axi_rd(SRW_OFF_CAUSE, rd, rr);
      check(rd[1] === 1'b0 && rr === SRW_RESP_OKAY, "manual cause not cleared");
      $display("Test manual reset and select done");
      // Renewed cause during hold restarts it
      sel <= 1'b0; mr_n <= 1'b0;
      cyc(8);
      mr_n <= 1'b1;
      cyc(10);
      mr_hold(1'b0, 1'b0, HS);
      $display("Test hold restart done");
      // Short dip ignored, long dip resets
      uv_in <= 1'b1;
      cyc(1900);
      uv_in <= 1'b0;
      cyc(10);
      check(rst_n === 1'b1, "short dip caused reset");
      uv_in <= 1'b1;
      cyc(2100);
      check(rst_n === 1'b0 && rst === 1'b1, "undervoltage not asserted");
      uv_in <= 1'b0;
      wait_lvl(1'b1, 500, n);
      check(n >= HS + 1 && n <= HS + 10, "hold after supply recovery");
      $display("Test undervoltage done");
      // Stuck program: watchdog expires, then healthy kicks keep it quiet
      run <= 1'b0;
      wait_lvl(1'b0, WD + 60, n);
      run <= 1'b1;
      wait_lvl(1'b1, 500, n);
      check(n >= HS - 1 && n <= HS + 2, "hold after watchdog expiry");
      cyc(400);
      check(rst_n === 1'b1, "watchdog fired despite kicks");
      $display("Test watchdog done");
      // Pin select off: the factory option times the hold, whatever the pin says
      axi_wr(SRW_OFF_CTRL, 32'h0000_0009, rr);
      mr_hold(1'b1, 1'b1, HF);
      $display("Test fixed hold option done");
      give_verdict;
   end
endmodule
`default_nettype wire
